// ### hdl/ebh_hold_ctrl.sv
// Purpose: hand the external memory bus to an outside master on request
// Assumes: bus_req_n_i asynchronous; memory controller reports busy
// Notes: bus pins are split into output value and output enable
`timescale 1ns/1ps
module ebh_hold_ctrl
  import ebh_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic bus_req_n_i,
  input wire logic grant_disable_i,
  input wire logic mem_busy_i,
  input wire logic [NUM_CE-1:0] ce_n_i,
  input wire logic [NUM_BE-1:0] byte_enables_i,
  input wire logic [DATA_W-1:0] mem_data_bus_i,
  input wire logic [ADDR_W-1:0] mem_word_addr_i,
  input wire logic async_read_strobe_i,
  input wire logic async_output_enable_i,
  input wire logic async_write_strobe_i,
  input wire logic col_strobe_or_burst_addr_strobe_i,
  input wire logic row_strobe_or_burst_out_enable_i,
  input wire logic sync_write_enable_i,
  input wire logic sdram_addr10_i,
  input wire logic mem_data_oe_i,
  output logic hold_stall_o,
  output logic bus_grant_ack_n_o,
  output logic bus_oe_o,
  output logic mem_data_oe_o,
  output logic [NUM_CE-1:0] ce_n_o,
  output logic [NUM_BE-1:0] byte_enables_o,
  output logic [DATA_W-1:0] mem_data_bus_o,
  output logic [ADDR_W-1:0] mem_word_addr_o,
  output logic async_read_strobe_o,
  output logic async_output_enable_o,
  output logic async_write_strobe_o,
  output logic col_strobe_or_burst_addr_strobe_o,
  output logic row_strobe_or_burst_out_enable_o,
  output logic sync_write_enable_o,
  output logic sdram_addr10_o
);
  localparam logic [3:0] REL_CNT = 4'(REL_MIN_CYC - SYNC_STAGES);
  localparam logic [3:0] DRV_CNT = 4'(DRV_MIN_CYC - SYNC_STAGES);

  logic req_sync;
  ebh_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic ack_n_ff, nxt_ack_n;
  logic oe_ff, nxt_oe;
  logic stall_ff, nxt_stall;
  localparam int PIN_W = DATA_W + ADDR_W + NUM_CE + NUM_BE + 7;
  logic [PIN_W-1:0] pins_ff, nxt_pins;
  logic dq_oe_ff, nxt_dq_oe;

  ebh_sync u_req_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .async_i(bus_req_n_i),
    .sync_o(req_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_ack_n = ack_n_ff;
    nxt_oe = oe_ff;
    nxt_stall = stall_ff;
    case (state_ff)
      ST_OWN: begin
        nxt_oe = 1'b1;
        nxt_ack_n = 1'b1;
        if (!req_sync && !grant_disable_i) begin
          nxt_state = ST_DRAIN;
          nxt_cnt = REL_CNT;
          nxt_stall = 1'b1;
        end
      end
      ST_DRAIN: begin
        if (cnt_ff != CNT_ZERO)
          nxt_cnt = cnt_ff - CNT_ONE;
        if (req_sync) begin
          nxt_state = ST_OWN;
          nxt_stall = 1'b0;
        end else if (cnt_ff <= CNT_ONE && !mem_busy_i) begin
          nxt_state = ST_FLOAT;
          nxt_oe = 1'b0;
        end
      end
      ST_FLOAT: begin
        nxt_ack_n = 1'b0;
        nxt_state = ST_GRANT;
      end
      ST_GRANT: begin
        if (req_sync) begin
          nxt_state = ST_RESUME;
          nxt_cnt = DRV_CNT;
        end
      end
      ST_RESUME: begin
        if (cnt_ff != CNT_ZERO)
          nxt_cnt = cnt_ff - CNT_ONE;
        if (cnt_ff <= CNT_ONE) begin
          nxt_oe = 1'b1;
          nxt_stall = 1'b0;
          nxt_state = ST_OWN;
        end
      end
      default: nxt_state = ST_OWN;
    endcase
    if (!rst_n_i) begin
      nxt_state = ST_OWN;
      nxt_cnt = CNT_ZERO;
      nxt_ack_n = 1'b1;
      nxt_oe = 1'b0;
      nxt_stall = 1'b0;
    end
  end

  always_comb begin
    nxt_pins = {ce_n_i, byte_enables_i, mem_data_bus_i, mem_word_addr_i,
      async_read_strobe_i, async_output_enable_i, async_write_strobe_i,
      col_strobe_or_burst_addr_strobe_i, row_strobe_or_burst_out_enable_i,
      sync_write_enable_i, sdram_addr10_i};
    nxt_dq_oe = nxt_oe & mem_data_oe_i;
    if (!rst_n_i)
      nxt_dq_oe = 1'b0;
  end

  always_ff @(posedge clk_sys_i) begin
    state_ff <= nxt_state;
    cnt_ff <= nxt_cnt;
    ack_n_ff <= nxt_ack_n;
    oe_ff <= nxt_oe;
    stall_ff <= nxt_stall;
    pins_ff <= nxt_pins;
    dq_oe_ff <= nxt_dq_oe;
  end

  assign hold_stall_o = stall_ff;
  assign bus_grant_ack_n_o = ack_n_ff;
  assign bus_oe_o = oe_ff;
  assign mem_data_oe_o = dq_oe_ff;
  assign {ce_n_o, byte_enables_o, mem_data_bus_o, mem_word_addr_o,
    async_read_strobe_o, async_output_enable_o, async_write_strobe_o,
    col_strobe_or_burst_addr_strobe_o, row_strobe_or_burst_out_enable_o,
    sync_write_enable_o, sdram_addr10_o} = pins_ff;

  ////////////////////////////////////////////////////////////////////////
  // ack low exactly one cycle after float
  property p_ack_after_float;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      $fell(oe_ff) |=> $fell(ack_n_ff);
  endproperty
  a_ack_after_float: assert property (p_ack_after_float)
    else $error("ack did not follow bus float");

  // ack only falls on a floating bus
  property p_no_ack_while_driven;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      $fell(ack_n_ff) |-> !oe_ff;
  endproperty
  a_no_ack_while_driven: assert property (p_no_ack_while_driven)
    else $error("ack low while bus driven");

  // ack rises only on a driven bus
  property p_ack_up_driven;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(ack_n_ff) |-> oe_ff;
  endproperty
  a_ack_up_driven: assert property (p_ack_up_driven)
    else $error("ack raised before bus driven");

  // request to float spans at least four cycles
  property p_float_min;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      $fell(bus_req_n_i) |-> oe_ff[*4];
  endproperty
  a_float_min: assert property (p_float_min)
    else $error("bus floated too early");

  property p_drain_busy;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_ff == ST_DRAIN && mem_busy_i) |=> oe_ff;
  endproperty
  a_drain_busy: assert property (p_drain_busy)
    else $error("bus released during transaction");

  property p_disable_hold;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_ff == ST_OWN && grant_disable_i) |=> state_ff != ST_DRAIN;
  endproperty
  a_disable_hold: assert property (p_disable_hold)
    else $error("grant started while disabled");

  property p_resume;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_ff == ST_GRANT && req_sync) |-> ##[1:5] oe_ff;
  endproperty
  a_resume: assert property (p_resume)
    else $error("bus not driven after release");

  property p_ack_rise;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(oe_ff) |-> ##[0:2] ack_n_ff;
  endproperty
  a_ack_rise: assert property (p_ack_rise)
    else $error("ack late after drive");

  property p_reset_state;
    @(posedge clk_sys_i) !rst_n_i |=> ack_n_ff && !oe_ff;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("reset outputs wrong");

  property p_reset_release;
    @(posedge clk_sys_i) $rose(rst_n_i) |-> ##[0:3] oe_ff;
  endproperty
  a_reset_release: assert property (p_reset_release)
    else $error("bus not driven after reset");

  c_grant: cover property (@(posedge clk_sys_i) $fell(ack_n_ff));
  c_return: cover property (@(posedge clk_sys_i) $rose(ack_n_ff));
  c_busy_drain: cover property (@(posedge clk_sys_i)
    state_ff == ST_DRAIN && mem_busy_i);
  c_defer: cover property (@(posedge clk_sys_i)
    state_ff == ST_OWN && grant_disable_i && !req_sync);
endmodule

// ### pkg/ebh_pkg.sv
// Purpose: constants for the external bus hold handshake
// Assumes: cpu clock 250 MHz (4 ns period)
// Notes: delays counted in cpu clock cycles
package ebh_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  // release no sooner than 4 periods after request low
  localparam int REL_MIN_P = 4;
  localparam int REL_MIN_CYC = REL_MIN_P;
  // drive again 3..7 periods after request high
  localparam int DRV_MIN_P = 3;
  localparam int DRV_MAX_P = 7;
  localparam int DRV_MIN_CYC = DRV_MIN_P;
  // acknowledge follows bus change within 2 periods
  localparam int ACK_MAX_P = 2;
  // outputs valid within 4 periods of reset release
  localparam int RST_VALID_P = 4;
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam int NUM_CE = 4;
  localparam int NUM_BE = 4;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 20;
  typedef enum logic [2:0] {
    ST_OWN = 3'b000,
    ST_DRAIN = 3'b001,
    ST_FLOAT = 3'b010,
    ST_GRANT = 3'b011,
    ST_RESUME = 3'b100
  } ebh_state_t;
endpackage

// ### hdl/ebh_sync.sv
// Purpose: two-flop synchroniser for the bus request pin
// Assumes: input is asynchronous to clk_sys_i
// Notes: resets to the idle (high) level of an active-low request
`timescale 1ns/1ps
module ebh_sync (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  always_comb begin
    nxt_meta = async_i;
    nxt_sync = meta_ff;
    if (!rst_n_i) begin
      nxt_meta = 1'b1;
      nxt_sync = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  assign sync_o = sync_ff;
endmodule

// ### testbench/ebh_master_model.sv
// Purpose: outside master that asks for the memory bus
// Assumes: go_i high means the master wants the bus
// Notes: drives its request just after the clock edge
`timescale 1ns/1ps
module ebh_master_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic go_i,
  input wire logic ack_n_i,
  output logic bus_req_n_o
);
  logic req_n_ff, nxt_req_n, seen_ff, nxt_seen;
  always_comb begin
    nxt_seen = !ack_n_i && !req_n_ff;
    nxt_req_n = req_n_ff;
    if (go_i) begin
      nxt_req_n = 1'b0;
    end else if (ack_n_i || seen_ff) begin
      nxt_req_n = 1'b1;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    req_n_ff <= rst_n_i ? nxt_req_n : 1'b1;
    seen_ff <= rst_n_i && nxt_seen;
  end
  assign bus_req_n_o = req_n_ff;
endmodule

// ### testbench/tb_ext_bus_hold_handshake.sv
// Purpose: self-checking bench for the bus hold handshake
// Assumes: pin inputs follow a changing pattern
// Notes: delays measured in cycles from the request edge
`timescale 1ns/1ps
module tb_ext_bus_hold_handshake;
  import ebh_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic go = 1'b0;
  logic gd = 1'b0;
  logic busy = 1'b0;
  logic [31:0] pat = 32'h0;
  logic [31:0] pat_d = 32'h0;
  logic req_n, ack_n, oe, doe, stall;
  logic [3:0] ce, be;
  logic [31:0] dat;
  logic [19:0] adr;
  logic [6:0] st;
  int err_total = 0;
  int n_compared = 0;
  int n;
  always #2 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    pat_d <= pat;
    #1 pat <= pat + 32'h9e3779b1;
  end
  ebh_master_model PM (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .go_i(go), .ack_n_i(ack_n), .bus_req_n_o(req_n));
  ebh_hold_ctrl DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .bus_req_n_i(req_n), .grant_disable_i(gd), .mem_busy_i(busy),
    .ce_n_i(pat[3:0]), .byte_enables_i(pat[7:4]),
    .mem_data_bus_i(pat), .mem_word_addr_i(pat[31:12]),
    .async_read_strobe_i(pat[8]), .async_output_enable_i(pat[9]),
    .async_write_strobe_i(pat[10]),
    .col_strobe_or_burst_addr_strobe_i(pat[11]),
    .row_strobe_or_burst_out_enable_i(pat[12]),
    .sync_write_enable_i(pat[13]), .sdram_addr10_i(pat[14]),
    .mem_data_oe_i(pat[15]), .hold_stall_o(stall),
    .bus_grant_ack_n_o(ack_n), .bus_oe_o(oe), .mem_data_oe_o(doe),
    .ce_n_o(ce), .byte_enables_o(be), .mem_data_bus_o(dat),
    .mem_word_addr_o(adr), .async_read_strobe_o(st[0]),
    .async_output_enable_o(st[1]), .async_write_strobe_o(st[2]),
    .col_strobe_or_burst_addr_strobe_o(st[3]),
    .row_strobe_or_burst_out_enable_o(st[4]),
    .sync_write_enable_o(st[5]), .sdram_addr10_o(st[6]));
  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input bit ok, input string msg);
    n_compared++;
    if (!ok) begin
      err_total++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask
  // bounded wait for bus enable (0), acknowledge (1) or request (2)
  task automatic wt(input int sel, input logic v, output int c);
    c = 0;
    while ((sel == 2 ? req_n : sel == 1 ? ack_n : oe) !== v && c < 40) begin
      tick();
      c++;
    end
    if (c >= 40) begin
      chk(1'b0, "wait ran out");
      stop_test();
    end
  endtask
  task automatic t_reset();
    rst_n_i = 1'b0;
    repeat (2) tick();
    chk(ack_n === 1'b1 && oe === 1'b0 &&
      doe === 1'b0 && stall === 1'b0, "reset pins");
    tick();
    rst_n_i = 1'b1;
    wt(0, 1'b1, n);
    chk(n <= RST_VALID_P && ack_n === 1'b1, "reset exit");
  endtask
  task automatic t_grant(input int hold);
    busy = (hold > 0);
    go = 1'b1;
    tick();
    for (int i = 0; i < hold; i++) begin
      tick();
      chk(ack_n === 1'b1 && oe === 1'b1 &&
        stall === (i >= SYNC_STAGES), "drain");
    end
    busy = 1'b0;
    wt(0, 1'b0, n);
    // the request changes just after an edge, so the synchroniser loses
    // the rest of that cycle; one more keeps a late request at 4 periods
    if (hold == 0) begin
      chk(n === REL_MIN_CYC + 1, "float delay");
    end
    wt(1, 1'b0, n);
    chk(n <= ACK_MAX_P && oe === 1'b0 && doe === 1'b0, "ack low");
    go = 1'b0;
    wt(2, 1'b1, n);
    chk(n >= 1, "request held");
    wt(0, 1'b1, n);
    chk(n >= DRV_MIN_P && n <= DRV_MAX_P, "drive delay");
    wt(1, 1'b1, n);
    chk(n <= ACK_MAX_P && stall === 1'b0, "ack high");
    tick();
    chk({ce, be, adr, dat} ===
      {pat_d[3:0], pat_d[7:4], pat_d[31:12], pat_d}, "pins");
    chk(st === pat_d[14:8] && doe === pat_d[15], "strobes");
  endtask
  task automatic t_abort();
    busy = 1'b1;
    go = 1'b1;
    repeat (4) tick();
    chk(stall === 1'b1 && oe === 1'b1, "drain started");
    go = 1'b0;
    repeat (8) begin
      tick();
      chk(ack_n === 1'b1 && oe === 1'b1, "abort kept bus");
    end
    chk(stall === 1'b0, "abort ended drain");
    busy = 1'b0;
  endtask
  task automatic t_disable();
    gd = 1'b1;
    go = 1'b1;
    repeat (20) begin
      tick();
      chk(ack_n === 1'b1 && oe === 1'b1 && stall === 1'b0,
        "grant deferred");
    end
    go = 1'b0;
    repeat (4) tick();
    gd = 1'b0;
  endtask
  task automatic t_mid_reset();
    go = 1'b1;
    wt(1, 1'b0, n);
    chk(oe === 1'b0, "granted before reset");
    go = 1'b0;
    t_reset();
  endtask
  initial begin
    t_reset();
    t_grant(0);
    t_grant(9);
    t_abort();
    t_disable();
    t_mid_reset();
    t_grant(0);
    stop_test();
  end
endmodule
